// >>> sram_port_defs.svh
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SRAM_ADDR_W 17
`define SRAM_LANE_W 9
`define SRAM_LANES 2
`define SRAM_BURST_W 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRAM_SEL_RST 1'b0
`define SRAM_WR_RST 1'b0
`define SRAM_RD_RST 1'b0
`define SRAM_CNT_RST 2'h0
`define SRAM_LINEAR_RST 1'b0
`define SRAM_SLEEP_RST 1'b0
`define SRAM_OE_RST 1'b0

// ----------------------------------------
// Timing counts at 125 MHz
// ----------------------------------------
`define SRAM_SLEEP_ENTRY_CYCLES 2
`define SRAM_SLEEP_EXIT_CYCLES 2

`endif

// >>> sram_port_pkg.sv
`include "sram_port_defs.svh"

package sram_port_pkg;

  // ----------------------------------------
  // Synchronous control pins
  // ----------------------------------------
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [`SRAM_LANES-1:0] byte_lane_select_n;
    logic primary_chip_select_n;
    logic expansion_chip_select;
    logic expansion_chip_select_n;
  } sram_ctrl_type;

  typedef enum logic {
    BURST_INTERLEAVED,
    BURST_LINEAR
  } burst_order_type;

endpackage : sram_port_pkg

// >>> pipelined_burst_sync_sram_port.sv
`timescale 1ns/1ps
`include "sram_port_defs.svh"

module pipelined_burst_sync_sram_port #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANE_W = `SRAM_LANE_W,
  parameter int LANES = `SRAM_LANES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire sram_port_pkg::sram_ctrl_type ctrl,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire logic [LANES*LANE_W-1:0] dq_in,
  output logic [LANES*LANE_W-1:0] dq_out,
  output logic dq_oe,
  output logic sleep_active
);
  import sram_port_pkg::*;

  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BW = `SRAM_BURST_W;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W <= BW || ADDR_W > 24) begin : g_bad_addr
    $error("address width out of range");
  end
  if (LANES != `SRAM_LANES || LANE_W < 1) begin : g_bad_lanes
    $error("lane count must match control struct");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [ADDR_W-1:BW] addr_hi_q;
  logic [BW-1:0] start_lo_q;
  logic [BW-1:0] cnt_q;
  logic sel_q;
  logic wr_q;
  logic rd_q;
  logic [LANES-1:0] lanes_q;
  logic [WORD_W-1:0] data_q;
  burst_order_type order_q;
  logic sleep_s1_q;
  logic sleep_active_q;
  logic [WORD_W-1:0] dq_out_q;
  logic dq_oe_q;

  // Next-cycle decode
  logic ce_all;
  logic p_go;
  logic c_go;
  logic strobe;
  logic [LANES-1:0] lanes_d;
  logic sel_d;
  logic wr_d;
  logic rd_d;
  logic [BW-1:0] lo_addr;
  logic [ADDR_W-1:0] cur_addr;
  logic [WORD_W-1:0] rd_word;

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  always_comb begin
    ce_all = !ctrl.primary_chip_select_n && ctrl.expansion_chip_select
      && !ctrl.expansion_chip_select_n;
    p_go = !ctrl.processor_addr_strobe_n && !ctrl.primary_chip_select_n;
    c_go = !ctrl.controller_addr_strobe_n && !p_go;
    strobe = p_go || c_go;
    if (!ctrl.global_write_n) begin
      lanes_d = '1;
    end else if (!ctrl.byte_write_enable_n) begin
      lanes_d = ~ctrl.byte_lane_select_n;
    end else begin
      lanes_d = '0;
    end
    if (strobe) begin
      sel_d = ce_all;
      // Processor strobe never writes; it opens a read only with all chip selects active
      wr_d = c_go && ce_all && (|lanes_d);
    end else begin
      sel_d = sel_q;
      wr_d = sel_q && (|lanes_d);
    end
    if (sleep_active_q) begin
      sel_d = 1'b0;
      wr_d = 1'b0;
    end
    rd_d = sel_d && !wr_d;
  end

  // ----------------------------------------
  // Burst address
  // ----------------------------------------
  always_comb begin
    if (order_q == BURST_LINEAR) begin
      lo_addr = start_lo_q + cnt_q;
    end else begin
      lo_addr = start_lo_q ^ cnt_q;
    end
    cur_addr = {addr_hi_q, lo_addr};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_hi_q <= '0;
      start_lo_q <= '0;
      cnt_q <= `SRAM_CNT_RST;
    end else if (strobe) begin
      addr_hi_q <= addr[ADDR_W-1:BW];
      start_lo_q <= addr[BW-1:0];
      cnt_q <= `SRAM_CNT_RST;
    end else if (sel_q && !ctrl.burst_advance_n && !sleep_active_q) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // Strap is static; sampling it every edge tracks the tie-off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      order_q <= BURST_INTERLEAVED;
    end else begin
      order_q <= burst_order_strap ? BURST_INTERLEAVED : BURST_LINEAR;
    end
  end

  // ----------------------------------------
  // Access pipeline
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_q <= `SRAM_SEL_RST;
      wr_q <= `SRAM_WR_RST;
      rd_q <= `SRAM_RD_RST;
      lanes_q <= '0;
      data_q <= '0;
    end else begin
      sel_q <= sel_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      lanes_q <= lanes_d;
      data_q <= dq_in;
    end
  end

  // ----------------------------------------
  // Storage, one array per byte lane
  // ----------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
      if (wr_q && lanes_q[l]) begin
        mem[cur_addr] <= data_q[l*LANE_W +: LANE_W];
      end
    end

    assign rd_word[l*LANE_W +: LANE_W] = mem[cur_addr];
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dq_out_q <= '0;
    end else if (rd_q) begin
      dq_out_q <= rd_word;
    end
  end

  // Enable follows the read registered one edge earlier, so a new
  // access out of deselect is off in its first cycle and a deselect
  // keeps the last word on the bus for one more cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dq_oe_q <= `SRAM_OE_RST;
    end else begin
      dq_oe_q <= rd_q && !output_enable_n && !wr_d && !sleep_active_q;
    end
  end

  // ----------------------------------------
  // Sleep request synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sleep_s1_q <= `SRAM_SLEEP_RST;
      sleep_active_q <= `SRAM_SLEEP_RST;
    end else begin
      sleep_s1_q <= sleep_request;
      sleep_active_q <= sleep_s1_q;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign sleep_active = sleep_active_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_sleep_held;
    sleep_request [*3];
  endsequence

  sequence s_sleep_clear;
    !sleep_request [*3];
  endsequence

  sequence s_adv_step;
    sel_q && !strobe && !ctrl.burst_advance_n && !sleep_active_q;
  endsequence

  sequence s_ctrl_load;
    c_go ##1 1'b1;
  endsequence

  a_sleep_entry_time: assert property (s_sleep_held |-> sleep_active_q)
    else $error("sleep not entered within two cycles");

  a_sleep_exit_time: assert property (s_sleep_clear |-> !sleep_active_q)
    else $error("sleep not left within two cycles");

  a_sleep_drops_access: assert property (sleep_active_q |=> !sel_q && !wr_q && !dq_oe_q)
    else $error("access survived sleep entry");

  a_burst_advance_step: assert property (s_adv_step |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("burst counter did not step");

  a_ctrl_load_ignores_adv: assert property (s_ctrl_load |-> cnt_q == 2'h0 && start_lo_q == $past(addr[1:0]))
    else $error("controller strobe load disturbed by advance");

  a_proc_no_write: assert property (p_go |=> !wr_q && cnt_q == 2'h0)
    else $error("processor strobe cycle wrote or advanced");

  a_write_mask_drive: assert property (wr_q |-> !dq_oe_q)
    else $error("data driven during write");

  a_drive_from_read: assert property (dq_oe_q |-> $past(rd_q) && !$past(output_enable_n))
    else $error("bus driven without a registered read");

  a_first_cycle_off: assert property ($rose(sel_q) |-> !dq_oe_q)
    else $error("driven in first cycle after deselect");

  a_deselect_tail: assert property ($fell(sel_q) |=> !dq_oe_q)
    else $error("drivers not off after deselect");

  a_global_all_lanes: assert property (wr_q && !$past(ctrl.global_write_n) |-> &lanes_q)
    else $error("global write missed a lane");

  a_both_strobes: assert property (p_go && !ctrl.controller_addr_strobe_n |=> !wr_q)
    else $error("controller strobe acted beside processor strobe");

endmodule : pipelined_burst_sync_sram_port

// >>> sram_host_model.sv
`timescale 1ns/1ps

module sram_host_model #(
  parameter int REC_CYCLES = 4
) (
  input wire logic clk_sys,
  output logic [16:0] addr,
  output sram_port_pkg::sram_ctrl_type ctrl,
  output logic [17:0] dq_in,
  output logic output_enable_n,
  output logic sleep_request
);
  import sram_port_pkg::*;

  // No strobe, chip selects inactive
  localparam sram_ctrl_type idle_ctrl = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 2'h3, 1'h1, 1'h0, 1'h1};

  initial begin
    ctrl = idle_ctrl;
    addr = 17'h00000;
    dq_in = 18'h00000;
    output_enable_n = 1'h1;
    sleep_request = 1'h0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic req(input logic ps_n, cs_n, gw_n, bwe_n, adv_n, sel, input logic [1:0] bl_n,
                     input logic [16:0] a, input logic [17:0] d);
    @(posedge clk_sys);
    ctrl <= '{ps_n, cs_n, adv_n, gw_n, bwe_n, bl_n, !sel, sel, !sel};
    addr <= a;
    dq_in <= d;
  endtask : req

  task automatic idle();
    @(posedge clk_sys);
    ctrl <= idle_ctrl;
    dq_in <= ~dq_in; // Released lines never keep the last value
  endtask : idle

  task automatic oe(input logic v);
    @(posedge clk_sys);
    output_enable_n <= v;
  endtask : oe

  task automatic wr(input logic gw_n, input logic [1:0] bl_n, input logic [16:0] a, input logic [17:0] d);
    if (output_enable_n !== 1'h1) oe(1'h1);
    req(1'h1, 1'h0, gw_n, 1'h0, 1'h1, 1'h1, bl_n, a, d);
    idle();
  endtask : wr

  task automatic rd(input logic p, input logic [16:0] a);
    req(!p, p, 1'h1, 1'h1, 1'h1, 1'h1, 2'h3, a, ~dq_in);
    output_enable_n <= 1'h0;
    idle();
  endtask : rd

  task automatic desel();
    req(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 2'h3, addr, ~dq_in);
  endtask : desel

  task automatic zz(input logic v);
    if (v) desel();
    @(posedge clk_sys);
    sleep_request <= v;
    repeat (REC_CYCLES) idle();
  endtask : zz
endmodule : sram_host_model

// >>> pipelined_burst_sync_sram_port_tb.sv
`timescale 1ns/1ps

module pipelined_burst_sync_sram_port_tb;
  import sram_port_pkg::*;

  typedef struct packed {
    logic [1:0] k;
    logic [16:0] a;
    logic [17:0] d;
  } row_type;

  logic clk_sys;
  logic resetn;
  logic burst_order_strap;
  logic [16:0] addr;
  sram_ctrl_type ctrl;
  logic [17:0] dq_in;
  logic [17:0] dq_out;
  logic output_enable_n;
  logic sleep_request;
  logic dq_oe;
  logic sleep_active;
  logic [1:0] s;
  int fail_count;
  int compares;
  row_type rows [9];

  sram_host_model host (.clk_sys(clk_sys), .addr(addr), .ctrl(ctrl), .dq_in(dq_in),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request));

  pipelined_burst_sync_sram_port dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .ctrl(ctrl),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order_strap(burst_order_strap), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .sleep_active(sleep_active));

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  task automatic chk_word(input string n, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic rd_chk(input logic p, input logic [16:0] a, input logic [17:0] e, input logic f);
    host.rd(p, a);
    if (f) begin
      #1;
      chk_bit("first cycle drive", 1'h0, dq_oe);
    end
    @(posedge clk_sys);
    #1;
    chk_word("read data", e, dq_out);
    chk_bit("read drive", 1'h1, dq_oe);
  endtask : rd_chk

  task automatic sleep_chk(input logic v);
    wait (sleep_request === v);
    @(posedge clk_sys);
    #1;
    chk_bit("sleep state", !v, sleep_active);
    @(posedge clk_sys);
    #1;
    chk_bit("sleep state", v, sleep_active);
  endtask : sleep_chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Whole run takes about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    resetn = 1'h0;
    burst_order_strap = 1'h1;
    rows = '{'{2'h0, 17'h00005, 18'h2AB01}, '{2'h1, 17'h00005, 18'h00077},
             '{2'h2, 17'h00005, 18'h2AA77}, '{2'h0, 17'h1FFFF, 18'h3C3C3},
             '{2'h3, 17'h1FFFF, 18'h3C3C3}, '{2'h0, 17'h00020, 18'h0A020},
             '{2'h0, 17'h00021, 18'h0A021}, '{2'h0, 17'h00022, 18'h0A022},
             '{2'h0, 17'h00023, 18'h0A023}};
    repeat (16) @(posedge clk_sys);
    #1;
    chk_word("reset data", 18'h00000, dq_out);
    chk_bit("reset drive", 1'h0, dq_oe);
    chk_bit("reset sleep", 1'h0, sleep_active);
    @(posedge clk_sys);
    resetn <= 1'h1;
    foreach (rows[i]) begin
      case (rows[i].k)
        2'h0: host.wr(1'h0, 2'h3, rows[i].a, rows[i].d);
        2'h1: host.wr(1'h1, 2'h2, rows[i].a, rows[i].d);
        default: rd_chk(rows[i].k[0], rows[i].a, rows[i].d, 1'h0);
      endcase
    end
    host.oe(1'h1);
    host.req(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 2'h0, 17'h00005, 18'h3FFFF);
    host.idle();
    rd_chk(1'h0, 17'h00005, 18'h2AA77, 1'h0);
    host.oe(1'h1);
    host.req(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 2'h3, 17'h00100, 18'h00000);
    host.req(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 2'h3, 17'h00000, 18'h15A5A);
    host.idle();
    rd_chk(1'h1, 17'h00100, 18'h15A5A, 1'h0);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      burst_order_strap <= !m[0];
      host.oe(1'h0);
      fork
        begin
          host.req(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 2'h3, 17'h00021, 18'h00000);
          repeat (3) host.req(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 2'h3, 17'h00000, 18'h00000);
          host.idle();
        end
        begin
          repeat (2) @(posedge clk_sys);
          for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            #1;
            s = m[0] ? 2'h1 + i[1:0] : 2'h1 ^ i[1:0];
            chk_word("burst word", 18'h0A020 + {16'h0000, s}, dq_out);
          end
        end
      join
    end
    host.req(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 2'h3, 17'h00000, 18'h00000);
    @(posedge clk_sys);
    #1;
    chk_bit("ignored strobe", 1'h1, dq_oe);
    @(posedge clk_sys);
    #1;
    chk_bit("ignored strobe", 1'h1, dq_oe);
    host.desel();
    @(posedge clk_sys);
    #1;
    chk_bit("deselect hold", 1'h1, dq_oe);
    @(posedge clk_sys);
    #1;
    chk_bit("deselect off", 1'h0, dq_oe);
    rd_chk(1'h0, 17'h00005, 18'h2AA77, 1'h1);
    fork
      host.zz(1'h1);
      sleep_chk(1'h1);
    join
    fork
      host.zz(1'h0);
      sleep_chk(1'h0);
    join
    rd_chk(1'h0, 17'h00005, 18'h2AA77, 1'h0);
    wrap_up();
  end
endmodule : pipelined_burst_sync_sram_port_tb
